/* rtl/jkx_flip_flop.sv */
// unknown-aware jk storage element sampled on a rising external clock edge
`timescale 1ns/1ps
`default_nettype none

// Operation
// - stored output changes only at a rising clock edge or while a forcing pin is high, otherwise holds
// - known steering: hold, clear, set, toggle; unknown stays unknown on hold/toggle
// - steering 0,1 loads 0 and 1,0 loads 1 even from unknown
// - set-steer known, clear-steer unknown: keep 0 or load 1 from 0, else unknown
// - set-steer unknown, clear-steer known: keep 1 or load 0 from 1, else unknown
// - both steering inputs unknown make the stored output unknown
module jkx_flip_flop
	import jkx_pkg::*;
#(
	parameter int unsigned INIT_STATE = JKX_INIT_ZERO	// initial_output_state: 0, 1 or 2
) (
	input  wire logic mclk,		// system clock, 100 MHz
	input  wire logic rst_n,	// async reset, active low
	input  wire logic clk_pin,	// external clock, rising edge samples
	input  wire logic j_lvl,	// set-steering level
	input  wire logic j_unk,	// set-steering is unknown
	input  wire logic k_lvl,	// clear-steering level
	input  wire logic k_unk,	// clear-steering is unknown
	input  wire logic set_pin,	// forcing set, active high
	input  wire logic reset_pin,	// forcing reset, active high
	output logic      q_lvl,	// true output level
	output logic      q_unk,	// true output is unknown
	output logic      qn_lvl,	// inverted output level
	output logic      qn_unk	// inverted output is unknown
);

	// =====================================================================
	// elaboration check
	if (INIT_STATE > JKX_INIT_MAX) begin : g_bad_init
		$error("jkx_flip_flop initial state selector out of range");
	end

	// =====================================================================
	// helpers
	// builds a three-valued level from a level and an unknown flag
	function automatic jkx_tri_t to_tri(input logic lvl, input logic unk);
		jkx_tri_t res;
		res = JKX_ZERO;
		if (unk) begin
			res = JKX_UNK;
		end else if (lvl) begin
			res = JKX_ONE;
		end
		return res;
	endfunction : to_tri

	// maps the initial state selector to a stored value
	function automatic jkx_tri_t init_tri(input int unsigned sel);
		jkx_tri_t res;
		res = JKX_ZERO;
		if (sel == JKX_INIT_ONE) begin
			res = JKX_ONE;
		end else if (sel == JKX_INIT_UNK) begin
			res = JKX_UNK;
		end
		return res;
	endfunction : init_tri

	// next stored value at a rising edge over the full three-valued space
	function automatic jkx_tri_t jk_next(input jkx_tri_t j, input jkx_tri_t k,
		input jkx_tri_t old);
		jkx_tri_t res;
		res = JKX_UNK;
		case ({j, k})
			{JKX_ZERO, JKX_ZERO}: res = old;
			{JKX_ZERO, JKX_ONE}:  res = JKX_ZERO;
			{JKX_ONE,  JKX_ZERO}: res = JKX_ONE;
			{JKX_ONE,  JKX_ONE}: begin
				if (old == JKX_ZERO) begin
					res = JKX_ONE;
				end else if (old == JKX_ONE) begin
					res = JKX_ZERO;
				end else begin
					res = JKX_UNK;
				end
			end
			{JKX_ZERO, JKX_UNK}: res = (old == JKX_ZERO) ? JKX_ZERO : JKX_UNK;
			{JKX_ONE,  JKX_UNK}: res = (old == JKX_ZERO) ? JKX_ONE : JKX_UNK;
			{JKX_UNK,  JKX_ZERO}: res = (old == JKX_ONE) ? JKX_ONE : JKX_UNK;
			{JKX_UNK,  JKX_ONE}: res = (old == JKX_ONE) ? JKX_ZERO : JKX_UNK;
			default: res = JKX_UNK;
		endcase
		return res;
	endfunction : jk_next

	localparam jkx_tri_t INIT_VAL = init_tri(INIT_STATE);	// reset image of the output

	// =====================================================================
	// pin conditioning
	wire logic [JKX_PIN_COUNT-1:0] pins_raw;	// raw pins in fixed order
	logic      [JKX_PIN_COUNT-1:0] pins_s;	// synchronised pins

	assign pins_raw[JKX_B_CLK]   = clk_pin;
	assign pins_raw[JKX_B_JLVL]  = j_lvl;
	assign pins_raw[JKX_B_JUNK]  = j_unk;
	assign pins_raw[JKX_B_KLVL]  = k_lvl;
	assign pins_raw[JKX_B_KUNK]  = k_unk;
	assign pins_raw[JKX_B_SET]   = set_pin;
	assign pins_raw[JKX_B_RESET] = reset_pin;

	// steering and clock share one chain so they stay aligned
	jkx_sync #(
		.WIDTH   (JKX_PIN_COUNT),
		.RST_VAL (JKX_PIN_RST_VAL)
	) u_sync (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.async_in (pins_raw),
		.sync_out (pins_s)
	);

	// =====================================================================
	// edge detect and decode
	logic     clk_prev_ff;	// synchronised clock, one cycle older
	jkx_tri_t q_ff;	// stored output
	jkx_tri_t nxt_q;	// next stored output

	wire logic     clk_rise = pins_s[JKX_B_CLK] & ~clk_prev_ff;	// one-cycle edge pulse
	wire logic     force_rst = pins_s[JKX_B_RESET];	// reset forcing wins over set
	wire logic     force_set = pins_s[JKX_B_SET];	// set forcing
	wire jkx_tri_t j_tri = to_tri(pins_s[JKX_B_JLVL], pins_s[JKX_B_JUNK]);
	wire jkx_tri_t k_tri = to_tri(pins_s[JKX_B_KLVL], pins_s[JKX_B_KUNK]);
	wire jkx_tri_t edge_val = jk_next(j_tri, k_tri, q_ff);	// value for an edge

	// forcing first, then edges, otherwise hold
	assign nxt_q = force_rst ? JKX_ZERO :
		force_set ? JKX_ONE :
		clk_rise  ? edge_val :
		q_ff;

	// =====================================================================
	// storage
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			clk_prev_ff <= JKX_PIN_RST_VAL[JKX_B_CLK];	// same as the chain's reset image
			q_ff        <= INIT_VAL;
		end else begin
			clk_prev_ff <= pins_s[JKX_B_CLK];
			q_ff        <= nxt_q;
		end
	end

	// both outputs decode the one stored value so they never disagree
	assign q_lvl  = (q_ff == JKX_ONE);
	assign q_unk  = (q_ff == JKX_UNK);
	assign qn_lvl = (q_ff == JKX_ZERO);
	assign qn_unk = (q_ff == JKX_UNK);

	// =====================================================================
	// checks
	wire logic quiet = ~clk_rise & ~force_rst & ~force_set;	// no cause to change

	hold_between_edges_a: assert property (@(posedge mclk) disable iff (!rst_n)
		quiet |=> $stable(q_ff))
		else $error("output moved without an edge or forcing");

	known_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_rise && !force_rst && !force_set && j_tri == JKX_ZERO && k_tri == JKX_ZERO)
		|=> q_ff == $past(q_ff))
		else $error("hold steering changed the output");

	known_toggle_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_rise && !force_rst && !force_set && j_tri == JKX_ONE && k_tri == JKX_ONE)
		|=> (($past(q_ff) == JKX_UNK) ? q_unk : ((q_lvl == $past(qn_lvl)) && !q_unk)))
		else $error("toggle steering did not invert the output");

	load_zero_one_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_rise && !force_rst && !force_set && !j_tri[1] && !k_tri[1] && (j_tri != k_tri))
		|=> q_ff == $past(j_tri))
		else $error("load steering did not load its level");

	set_known_clr_unk_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_rise && !force_rst && !force_set && j_tri != JKX_UNK && k_tri == JKX_UNK)
		|=> q_ff == (($past(q_ff) == JKX_ZERO) ? $past(j_tri) : JKX_UNK))
		else $error("unknown clear-steering resolved wrongly");

	set_unk_clr_known_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_rise && !force_rst && !force_set && j_tri == JKX_UNK && k_tri != JKX_UNK)
		|=> q_ff == (($past(q_ff) == JKX_ONE) ? (($past(k_tri) == JKX_ONE) ? JKX_ZERO :
			JKX_ONE) : JKX_UNK))
		else $error("unknown set-steering resolved wrongly");

	both_unknown_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_rise && !force_rst && !force_set && j_tri == JKX_UNK && k_tri == JKX_UNK)
		|=> q_unk && qn_unk)
		else $error("both unknown did not give unknown");

	force_pins_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(force_rst || force_set) |=> (q_lvl == !$past(force_rst)) && !q_unk)
		else $error("forcing pins did not set the output");

	complement_a: assert property (@(posedge mclk) disable iff (!rst_n)
		q_unk ? (qn_unk && !q_lvl && !qn_lvl) : (qn_lvl == !q_lvl && !qn_unk))
		else $error("inverted output is not the complement");

	pin_latency_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(reset_pin) ##1 reset_pin ##1 reset_pin |=> qn_lvl)
		else $error("reset pin not seen at the output in three cycles");

	// an edge taken while set forcing alone is high must leave the forced value alone
	forced_blocks_edge_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_rise && force_set && !force_rst) |=> q_ff == JKX_ONE)
		else $error("clock edge moved a forced output");

	// one external rising edge is taken exactly once
	edge_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clk_rise |=> !clk_rise)
		else $error("one clock edge sampled twice");

	// set pin alone reaches the output three cycles after it rises
	set_latency_a: assert property (@(posedge mclk) disable iff (!rst_n)
		($rose(set_pin) && !reset_pin) ##1 (set_pin && !reset_pin) ##1 (set_pin && !reset_pin)
		|=> q_lvl && !q_unk)
		else $error("set pin not seen at the output in three cycles");

endmodule : jkx_flip_flop

`default_nettype wire

/* rtl/jkx_pkg.sv */
// shared constants and types for the unknown-aware jk storage element
package jkx_pkg;

	// =====================================================================
	// three-valued level encoding
	typedef enum logic [1:0] {
		JKX_ZERO = 2'h0,	// known low
		JKX_ONE  = 2'h1,	// known high
		JKX_UNK  = 2'h3		// unknown, one bit away from high
	} jkx_tri_t;

	// =====================================================================
	// initial output state selector values
	localparam int unsigned JKX_INIT_ZERO = 0;	// start low
	localparam int unsigned JKX_INIT_ONE  = 1;	// start high
	localparam int unsigned JKX_INIT_UNK  = 2;	// start unknown
	localparam int unsigned JKX_INIT_MAX  = 2;	// largest legal selector

	// =====================================================================
	// pin conditioning
	localparam int unsigned JKX_SYNC_STAGES = 2;	// flops ahead of any logic
	localparam int unsigned JKX_PIN_COUNT   = 7;	// pins carried through the synchroniser
	localparam logic [6:0]  JKX_PIN_RST_VAL = 7'h00;	// synchroniser reset image

	// bit positions inside the synchronised pin vector
	localparam int unsigned JKX_B_CLK   = 0;	// external clock pin
	localparam int unsigned JKX_B_JLVL  = 1;	// set-steering level
	localparam int unsigned JKX_B_JUNK  = 2;	// set-steering unknown flag
	localparam int unsigned JKX_B_KLVL  = 3;	// clear-steering level
	localparam int unsigned JKX_B_KUNK  = 4;	// clear-steering unknown flag
	localparam int unsigned JKX_B_SET   = 5;	// forcing set
	localparam int unsigned JKX_B_RESET = 6;	// forcing reset

endpackage : jkx_pkg

/* rtl/jkx_sync.sv */
// two-stage level synchroniser for a vector of pins
`timescale 1ns/1ps
`default_nettype none

module jkx_sync #(
	parameter int unsigned        WIDTH   = 7,	// number of pins
	parameter logic [WIDTH-1:0]   RST_VAL = '0	// value held during reset
) (
	input  wire logic             mclk,		// system clock
	input  wire logic             rst_n,		// async reset, active low
	input  wire logic [WIDTH-1:0] async_in,	// raw pin levels
	output logic      [WIDTH-1:0] sync_out	// levels safe to use
);

	// =====================================================================
	// elaboration check
	if (WIDTH < 1) begin : g_bad_width
		$error("jkx_sync width must be at least one");
	end

	logic [WIDTH-1:0] meta_ff;	// first stage, read only by the second
	logic [WIDTH-1:0] sync_ff;	// second stage

	// =====================================================================
	// capture chain
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;	// registered output

endmodule : jkx_sync

`default_nettype wire

/* test/jkx_flip_flop_tb.sv */
// self-checking bench for the unknown-aware jk storage element
`timescale 1ns/1ps
`default_nettype none

module jkx_flip_flop_tb;
	import jkx_pkg::*;

	// =====================================================================
	// stimulus and observed signals
	logic mclk      = 1'b0;	// system clock
	logic rst_n     = 1'b0;	// async reset, active low
	logic clk_pin   = 1'b0;	// external jk clock
	logic j_lvl     = 1'b0;	// set-steering level
	logic j_unk     = 1'b0;	// set-steering unknown
	logic k_lvl     = 1'b0;	// clear-steering level
	logic k_unk     = 1'b0;	// clear-steering unknown
	logic set_pin   = 1'b0;	// forcing set
	logic reset_pin = 1'b0;	// forcing reset
	logic q_lvl, q_unk, qn_lvl, qn_unk;	// outputs
	int   bad_count = 0;	// mismatches
	int   n_checks  = 0;	// comparisons made
	int   cycles    = 0;	// hang guard

	jkx_flip_flop u_jkx_flip_flop (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.clk_pin   (clk_pin),
		.j_lvl     (j_lvl),
		.j_unk     (j_unk),
		.k_lvl     (k_lvl),
		.k_unk     (k_unk),
		.set_pin   (set_pin),
		.reset_pin (reset_pin),
		.q_lvl     (q_lvl),
		.q_unk     (q_unk),
		.qn_lvl    (qn_lvl),
		.qn_unk    (qn_unk)
	);

	// =====================================================================
	// clock and hang guard
	always #5 mclk = ~mclk;

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count = bad_count + 1;
			test_done();
		end
	end

	// =====================================================================
	// shared tasks
	task automatic test_done();
		if (bad_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	// compare all four outputs against one three-valued level
	task automatic check(input jkx_tri_t exp);
		#1;
		n_checks = n_checks + 1;
		if (q_lvl !== (exp == JKX_ONE) || q_unk !== (exp == JKX_UNK) ||
			qn_lvl !== (exp == JKX_ZERO) || qn_unk !== (exp == JKX_UNK)) begin
			bad_count = bad_count + 1;
			$display("CHECK FAILED %0t output %b%b/%b%b expected %0d",
				$time, q_lvl, q_unk, qn_lvl, qn_unk, exp);
		end
	endtask : check

	// one jk clock event; an unknown input shows a flipped, meaningless level
	task automatic step(input jkx_tri_t j, input jkx_tri_t k, input jkx_tri_t exp);
		@(posedge mclk);
		j_unk   <= (j == JKX_UNK);
		j_lvl   <= (j == JKX_UNK) ? ~j_lvl : j[0];
		k_unk   <= (k == JKX_UNK);
		k_lvl   <= (k == JKX_UNK) ? ~k_lvl : k[0];
		clk_pin <= 1'b0;
		repeat (3) @(posedge mclk);
		clk_pin <= 1'b1;
		repeat (5) @(posedge mclk);
		check(exp);
	endtask : step

	// =====================================================================
	// scenarios
	task automatic t_known();
		step(JKX_ONE, JKX_ZERO, JKX_ONE);
		step(JKX_ZERO, JKX_ZERO, JKX_ONE);
		step(JKX_ONE, JKX_ONE, JKX_ZERO);
		step(JKX_ZERO, JKX_ZERO, JKX_ZERO);
		step(JKX_ONE, JKX_ONE, JKX_ONE);
		step(JKX_ZERO, JKX_ONE, JKX_ZERO);
	endtask : t_known

	// steering moves and a falling edge must not disturb the output
	task automatic t_between();
		step(JKX_ONE, JKX_ZERO, JKX_ONE);
		@(posedge mclk);
		j_lvl <= 1'b0;
		k_lvl <= 1'b1;
		repeat (5) @(posedge mclk);
		clk_pin <= 1'b0;
		repeat (5) @(posedge mclk);
		check(JKX_ONE);
	endtask : t_between

	task automatic t_unknown();
		step(JKX_UNK, JKX_UNK, JKX_UNK);
		step(JKX_ZERO, JKX_ZERO, JKX_UNK);
		step(JKX_ONE, JKX_ONE, JKX_UNK);
		step(JKX_ZERO, JKX_ONE, JKX_ZERO);
		step(JKX_UNK, JKX_UNK, JKX_UNK);
		step(JKX_ONE, JKX_ZERO, JKX_ONE);
		step(JKX_UNK, JKX_UNK, JKX_UNK);
	endtask : t_unknown

	task automatic t_half_known();
		step(JKX_ZERO, JKX_ONE, JKX_ZERO);
		step(JKX_ZERO, JKX_UNK, JKX_ZERO);
		step(JKX_ONE, JKX_UNK, JKX_ONE);
		step(JKX_ZERO, JKX_UNK, JKX_UNK);
		step(JKX_ONE, JKX_ZERO, JKX_ONE);
		step(JKX_ONE, JKX_UNK, JKX_UNK);
		step(JKX_ONE, JKX_ZERO, JKX_ONE);
		step(JKX_UNK, JKX_ZERO, JKX_ONE);
		step(JKX_UNK, JKX_ONE, JKX_ZERO);
		step(JKX_UNK, JKX_ZERO, JKX_UNK);
		step(JKX_ZERO, JKX_ONE, JKX_ZERO);
		step(JKX_UNK, JKX_ONE, JKX_UNK);
	endtask : t_half_known

	// forcing overrides the jk clock and persists after release
	task automatic t_force();
		@(posedge mclk);
		set_pin <= 1'b1;
		repeat (4) @(posedge mclk);
		check(JKX_ONE);
		step(JKX_ZERO, JKX_ONE, JKX_ONE);
		@(posedge mclk);
		set_pin <= 1'b0;
		repeat (4) @(posedge mclk);
		check(JKX_ONE);
		@(posedge mclk);
		set_pin   <= 1'b1;
		reset_pin <= 1'b1;
		repeat (4) @(posedge mclk);
		check(JKX_ZERO);
		@(posedge mclk);
		set_pin   <= 1'b0;
		reset_pin <= 1'b0;
		step(JKX_ONE, JKX_ZERO, JKX_ONE);
		@(posedge mclk);
		rst_n   <= 1'b0;
		clk_pin <= 1'b0;	// low clock pin, so release brings no false edge
		repeat (2) @(posedge mclk);
		check(JKX_ZERO);
		@(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		check(JKX_ZERO);
	endtask : t_force

	// =====================================================================
	// main sequence
	initial begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		check(JKX_ZERO);
		t_known();
		t_between();
		t_unknown();
		t_half_known();
		t_force();
		t_known();
		test_done();
	end

endmodule : jkx_flip_flop_tb

`default_nettype wire
